/* File: bench/ssf_chk.sv */
// Checker for the sample buffer, seeing only the ports of ssf_top.
// Assumes register writes and reads never share a cycle with a start.
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_chk (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  // Register port
  input wire logic                   reg_start_i,
  input wire logic [`SSF_ADDR_W-1:0] reg_addr_i,
  input wire logic                   reg_wr_i,
  input wire logic [`SSF_DATA_W-1:0] reg_wdata_i,
  input wire logic                   reg_rd_i,
  input wire logic [`SSF_DATA_W-1:0] reg_rdata_o,
  // Sample port, flag and pin
  input wire logic                   sample_ready_o,
  input wire logic                   interrupt_active_flag_i,
  input wire logic                   interrupt_pin_o
);
  logic [6:0] ptr_q;
  logic [7:0] c2_q;
  logic [7:0] c3_q;
  logic [7:0] bc_q;
  wire        rd_at = reg_rd_i && !reg_start_i;
  wire [2:0]  md    = bc_q[7:5];
  // Modes that never refuse a sample, whatever the level
  wire        flow  = !c2_q[6] || md == 3'h0 || md == 3'h2 || md == 3'h4 || md == 3'h5
                      || md == 3'h6 || (md[0] && md[1] && !interrupt_active_flag_i);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ptr_q <= 7'h00;
    else if (reg_start_i) ptr_q <= reg_addr_i;
    else if (reg_rd_i || reg_wr_i) ptr_q <= (ptr_q == 7'h2c) ? 7'h28 : ptr_q + 7'h01;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c2_q <= 8'h00;
      c3_q <= 8'h00;
      bc_q <= 8'h00;
    end else if (reg_wr_i && !reg_start_i) begin
      if (ptr_q == 7'h11) c2_q <= reg_wdata_i;
      if (ptr_q == 7'h12) c3_q <= reg_wdata_i;
      if (ptr_q == 7'h14) bc_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_ready_flow: assert property (
    flow |-> sample_ready_o) else $error("sample refused outside stop mode");
  a_ctrl_readback: assert property (
    rd_at && ptr_q == 7'h14 |=> reg_rdata_o == $past(bc_q)) else $error("mode readback");
  a_status_bypass: assert property (
    rd_at && ptr_q == 7'h26 && (!c2_q[6] || md == 3'h0) |=> reg_rdata_o[5:0] == 6'h00)
    else $error("bypass level not empty");
  a_wtm_zero: assert property (
    rd_at && ptr_q == 7'h26 && bc_q[4:0] == 5'h00 |=> !reg_rdata_o[7])
    else $error("watermark flag with zero watermark");
  a_src_flag: assert property (
    rd_at && ptr_q == 7'h25 |=> reg_rdata_o[2] == $past(interrupt_active_flag_i))
    else $error("interrupt source bit");
  a_unmapped_zero: assert property (
    rd_at && ptr_q > 7'h2c |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  a_pin_off: assert property (
    c3_q[4:3] == 2'h0 |=> !interrupt_pin_o) else $error("pin high while disabled");
  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without read");
endmodule : ssf_chk

bind ssf_top ssf_chk ssf_chk_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_start_i(reg_start_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sample_ready_o(sample_ready_o),
  .interrupt_active_flag_i(interrupt_active_flag_i), .interrupt_pin_o(interrupt_pin_o));

/* File: bench/ssf_host.sv */
// Host model: one register access at a time over the register port.
// Assumes it drives on falling edges; read bytes land in b[].
`timescale 1ns/1ps
module ssf_host (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic            start_o,
  output logic [6:0]      addr_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  logic [7:0] b [0:159];
  initial begin
    {start_o, wr_o, rd_o} = 3'h0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    start_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    start_o = 1'b0;
    wr_o = 1'b1;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
  endtask : wr
  // Burst read: address advances and wraps inside the device
  task automatic rd(input logic [6:0] a, input int n);
    @(negedge clk_i);
    start_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    start_o = 1'b0;
    rd_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      b[i] = rdata_i;
      if (i == n - 1) rd_o = 1'b0;
    end
  endtask : rd
endmodule : ssf_host

/* File: bench/tb_ssf_top.sv */
// Testbench for the sample buffer: host model on the register port, bench on samples.
// Assumes 100 MHz clock and inputs driven on falling edges.
`timescale 1ns/1ps
module tb_ssf_top;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        sample_valid_i = 1'b0;
  logic [23:0] pressure_i = 24'h000000;
  logic [15:0] temperature_i = 16'h0000;
  logic        interrupt_active_flag_i = 1'b0;
  logic        reg_start_i, reg_wr_i, reg_rd_i, sample_ready_o, interrupt_pin_o;
  logic [6:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o;
  int          n_fail = 0, total_checks = 0, cyc = 0, seq = 0, acc, b0;
  ssf_top ssf_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_start_i(reg_start_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .pressure_i(pressure_i), .temperature_i(temperature_i),
    .interrupt_active_flag_i(interrupt_active_flag_i), .interrupt_pin_o(interrupt_pin_o));
  ssf_host ssf_host_i (.clk_i(clk_i), .start_o(reg_start_i), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .wdata_o(reg_wdata_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end
  // Sample n: temp {n^5a, n}, pressure {n, c3, ~n} so every byte but the c3 one changes with n
  function automatic logic [39:0] ent(input int n);
    ent = {n[7:0] ^ 8'h5a, n[7:0], n[7:0], 8'hc3, ~n[7:0]};
  endfunction : ent
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Offer k samples back to back; acc counts those taken
  task automatic push(input int k);
    acc = 0;
    repeat (k) begin
      @(negedge clk_i);
      sample_valid_i = 1'b1;
      {temperature_i, pressure_i} = ent(seq);
      seq++;
      #1 if (sample_ready_o === 1'b1) acc++;
    end
    @(negedge clk_i);
    sample_valid_i = 1'b0;
  endtask : push
  task automatic ents(input int n, input int first);
    logic [39:0] got;
    ssf_host_i.rd(7'h28, 5 * n);
    for (int j = 0; j < n; j++) begin
      got = {ssf_host_i.b[5*j+4], ssf_host_i.b[5*j+3], ssf_host_i.b[5*j+2],
        ssf_host_i.b[5*j+1], ssf_host_i.b[5*j]};
      chk("entry", got, ent(first + j));
    end
  endtask : ents
  task automatic stat(input logic [7:0] exp);
    ssf_host_i.rd(7'h26, 1);
    chk("status", {32'h0, ssf_host_i.b[0]}, {32'h0, exp});
  endtask : stat
  task automatic mode(input logic [7:0] v);
    ssf_host_i.wr(7'h14, 8'h00);
    ssf_host_i.wr(7'h14, v);
  endtask : mode
  task automatic t_bypass();
    ssf_host_i.wr(7'h11, 8'h40);
    push(2);
    ents(1, seq - 1);
    stat(8'h00);
    ssf_host_i.rd(7'h30, 1);
    chk("unmapped", {32'h0, ssf_host_i.b[0]}, 40'h0);
    $display("done bypass");
  endtask : t_bypass
  task automatic t_fifo();
    mode(8'h20);
    b0 = seq;
    push(34);
    chk("taken", 40'(acc), 40'h20);
    stat(8'h20);
    ents(32, b0);
    stat(8'h00);
    $display("done fifo");
  endtask : t_fifo
  task automatic t_stop();
    ssf_host_i.wr(7'h12, 8'h10);
    ssf_host_i.wr(7'h11, 8'h60);
    mode(8'h23);
    push(6);
    chk("taken", 40'(acc), 40'h4);
    stat(8'h84);
    chk("pin", {39'h0, interrupt_pin_o}, 40'h1);
    ssf_host_i.wr(7'h11, 8'h40);
    $display("done stop");
  endtask : t_stop
  task automatic t_stream();
    ssf_host_i.wr(7'h12, 8'h08);
    mode(8'h40);
    b0 = seq;
    push(34);
    chk("taken", 40'(acc), 40'h22);
    stat(8'h60);
    chk("pin", {39'h0, interrupt_pin_o}, 40'h1);
    ents(32, b0 + 2);
    push(1);
    stat(8'h42);
    ents(2, b0 + 33);
    ssf_host_i.wr(7'h12, 8'h00);
    $display("done stream");
  endtask : t_stream
  task automatic t_dyn();
    mode(8'hc0);
    push(1);
    ssf_host_i.rd(7'h28, 5); // First sample after the switch is thrown away
    b0 = seq;
    push(2);
    ents(2, b0);
    push(1);
    stat(8'h01);
    ents(1, b0 + 2);
    $display("done dynamic");
  endtask : t_dyn
  task automatic t_flag();
    ssf_host_i.wr(7'h0b, 8'h04); // Latched source flag assumed upstream
    mode(8'h80);
    push(2);
    stat(8'h00);
    interrupt_active_flag_i = 1'b1;
    push(3);
    stat(8'h03);
    interrupt_active_flag_i = 1'b0;
    mode(8'he0);
    push(1);
    stat(8'h00);
    interrupt_active_flag_i = 1'b1;
    push(33);
    chk("taken", 40'(acc), 40'h20);
    interrupt_active_flag_i = 1'b0;
    mode(8'h60);
    push(33);
    chk("taken", 40'(acc), 40'h21);
    interrupt_active_flag_i = 1'b1;
    push(1);
    chk("taken", 40'(acc), 40'h0);
    ssf_host_i.rd(7'h25, 1);
    chk("source", {39'h0, ssf_host_i.b[0][2]}, 40'h1);
    interrupt_active_flag_i = 1'b0;
    ssf_host_i.wr(7'h11, 8'h00);
    stat(8'h00);
    $display("done flag modes");
  endtask : t_flag
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    t_bypass();
    t_fifo();
    t_stop();
    t_stream();
    t_dyn();
    t_flag();
    close_out();
  end
endmodule : tb_ssf_top

/* File: core/ssf_defs.svh */
// Register offsets, field positions, mode codes and reset values for the sample buffer.
// Assumes a 7-bit internal register address and 8-bit register data.
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

`define SSF_ADDR_W          7
`define SSF_DATA_W          8
`define SSF_ENTRY_W         40
`define SSF_DEPTH           32
`define SSF_PTR_W           5
`define SSF_LVL_W           6

`define SSF_OFF_INT_CFG     7'h0b
`define SSF_OFF_CTRL2       7'h11
`define SSF_OFF_CTRL3       7'h12
`define SSF_OFF_BUF_CTRL    7'h14
`define SSF_OFF_INT_SRC     7'h25
`define SSF_OFF_STATUS      7'h26
`define SSF_OFF_PRESS_LO    7'h28
`define SSF_OFF_PRESS_MID   7'h29
`define SSF_OFF_PRESS_HI    7'h2a
`define SSF_OFF_TEMP_LO     7'h2b
`define SSF_OFF_TEMP_HI     7'h2c

`define SSF_CTRL2_EN_BIT    6
`define SSF_CTRL2_STOP_BIT  5
`define SSF_CTRL3_FTH_BIT   4
`define SSF_CTRL3_OVR_BIT   3
`define SSF_INTSRC_IA_BIT   2
`define SSF_STAT_FTH_BIT    7
`define SSF_STAT_OVR_BIT    6
`define SSF_MODE_MSB        7
`define SSF_MODE_LSB        5
`define SSF_WTM_MSB         4
`define SSF_POS_PRESS_MID   8
`define SSF_POS_PRESS_HI    16
`define SSF_POS_TEMP_LO     24
`define SSF_POS_TEMP_HI     32

`define SSF_MODE_BYPASS     3'h0
`define SSF_MODE_FIFO       3'h1
`define SSF_MODE_STREAM     3'h2
`define SSF_MODE_S2F        3'h3
`define SSF_MODE_B2S        3'h4
`define SSF_MODE_DYN        3'h6
`define SSF_MODE_B2F        3'h7

`define SSF_RST_REG         8'h00
`define SSF_LVL_ONE         6'h01
`define SSF_LVL_TWO         6'h02
`define SSF_PTR_ONE         5'h01

`endif

/* File: core/ssf_pkg.sv */
// Types shared by the sample buffer logic.
// Assumes ssf_defs.svh supplies all numeric constants.
package ssf_pkg;

  typedef enum logic [1:0] {
    SSF_EFF_BYPASS,
    SSF_EFF_STOP,
    SSF_EFF_STREAM,
    SSF_EFF_DYNAMIC
  } ssf_eff_mode_t;

endpackage : ssf_pkg

/* File: core/ssf_top.sv */
// Sample buffer: 32 x 40-bit store of pressure/temperature pairs with its registers.
// Assumes a serial front end on clk_i that starts accesses with reg_start_i and
// a measurement chain and threshold generator on the same clock.
//
// How it works
// - Buffer holds 32 entries of 40 bits, pressure with matching temperature.
// - Enable bit in control_two gates buffer; three-bit mode field picks behaviour.
// - Watermark flag is unread count at or above watermark, zero if watermark zero.
// - Overrun flag sets whenever a stored unread entry is overwritten.
// - Six-bit fill level reports unread count, 0 empty, 32 full.
// - Bypass stores nothing; each result overwrites only the presented entry.
// - Writing bypass clears contents; host restarts by writing fifo mode.
// - Fifo mode stores results until full, then ignores new ones.
// - Stop-on-threshold limits depth to watermark plus one entries.
// - Stream mode accepts every result, dropping oldest when full.
// - Stream mode keeps last read entry; level steps 0 to 2 afterwards.
// - Overrun enable drives interrupt pin on full overwrite; oldest entry is lost.
// - Dynamic stream returns first new result next and counts only new samples.
// - Threshold enable drives watermark condition onto the interrupt pin.
// - Mode 011 streams while interrupt flag low, stops when full while high.
// - Mode 100 streams while interrupt flag high, bypass-cleared while low.
// - Mode 111 stops when full while flag high, bypass-cleared while low.
// - Reads present oldest entry in five output registers; single and burst.
// - Burst address auto-advances and wraps from 2Ch back to 28h.
// - Pressure is 24-bit two's complement, high 2Ah, middle 29h, low 28h.
`timescale 1ns/1ps
`include "ssf_defs.svh"

module ssf_buffer #(
  parameter int WIDTH = `SSF_ENTRY_W,
  parameter int DEPTH = `SSF_DEPTH,
  parameter int PW    = `SSF_PTR_W,
  parameter int LW    = `SSF_LVL_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Policy
  input  wire logic             clear_i,
  input  wire logic             overwrite_i,
  input  wire logic             retain_i,
  input  wire logic [LW-1:0]    limit_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  // Status
  output logic [LW-1:0]         level_o,
  output logic                  overrun_o
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [LW-1:0]    count_q;
  logic             retain_q;
  logic             full;
  logic             push;
  logic             pop;
  logic             drop;
  logic             rd_adv;

  assign full        = (count_q >= limit_i);
  assign in_ready_o  = !clear_i && (!full || overwrite_i);
  assign push        = in_valid_i && in_ready_o;
  assign drop        = push && full;
  assign out_valid_o = (count_q != '0);
  assign pop         = out_valid_o && out_ready_i && !clear_i;
  assign rd_adv      = pop || drop;
  assign out_data_o  = mem[rd_ptr_q];
  assign level_o     = count_q;
  assign overrun_o   = drop;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (clear_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + `SSF_PTR_ONE;
      end
      if (push && retain_q) begin
        // Step back onto the entry that was read last
        rd_ptr_q <= rd_ptr_q - `SSF_PTR_ONE;
        count_q  <= `SSF_LVL_TWO;
      end else begin
        if (rd_adv) begin
          rd_ptr_q <= rd_ptr_q + `SSF_PTR_ONE;
        end
        if (push && !rd_adv) begin
          count_q <= count_q + `SSF_LVL_ONE;
        end else if (!push && rd_adv) begin
          count_q <= count_q - `SSF_LVL_ONE;
        end
      end
    end
  end

  // Dynamic stream never retains, so its level counts only new samples
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      retain_q <= 1'b0;
    end else if (clear_i || !retain_i || push) begin
      retain_q <= 1'b0;
    end else if (pop && count_q == `SSF_LVL_ONE) begin
      retain_q <= 1'b1;
    end
  end

endmodule : ssf_buffer

module ssf_top (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // Register port from the serial front end
  input  wire logic                     reg_start_i,
  input  wire logic [`SSF_ADDR_W-1:0]   reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [`SSF_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                     reg_rd_i,
  output logic [`SSF_DATA_W-1:0]        reg_rdata_o,
  // Measurement chain results
  input  wire logic                     sample_valid_i,
  output logic                          sample_ready_o,
  input  wire logic [23:0]              pressure_i,
  input  wire logic [15:0]              temperature_i,
  // Threshold interrupt generator
  input  wire logic                     interrupt_active_flag_i,
  // Pin
  output logic                          interrupt_pin_o
);

  logic [`SSF_DATA_W-1:0]  int_cfg_q;
  logic [`SSF_DATA_W-1:0]  control_two_q;
  logic [`SSF_DATA_W-1:0]  control_three_q;
  logic [`SSF_DATA_W-1:0]  buf_ctrl_q;
  logic [`SSF_ADDR_W-1:0]  addr_q;
  logic [`SSF_ENTRY_W-1:0] last_q;
  logic                    overrun_flag_q;
  logic [`SSF_DATA_W-1:0]  rdata_q;

  logic [2:0]              buffer_mode_bits;
  logic [4:0]              watermark_level;
  logic                    buf_en;
  logic                    stop_on_threshold;
  logic                    overrun_irq_enable;
  logic                    threshold_irq_enable;
  logic                    ia;
  ssf_pkg::ssf_eff_mode_t  eff_mode;
  logic                    bypass;
  logic [`SSF_LVL_W-1:0]   limit;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_pop;
  logic [`SSF_ENTRY_W-1:0] fifo_head;
  logic [`SSF_LVL_W-1:0]   fill_level;
  logic                    fifo_drop;
  logic                    watermark_flag;
  logic [`SSF_ENTRY_W-1:0] cur_entry;
  logic [`SSF_DATA_W-1:0]  rdata_d;
  logic [`SSF_DATA_W-1:0]  status_byte;
  logic [`SSF_DATA_W-1:0]  int_src_byte;
  logic                    acc;
  logic                    wr_go;
  logic                    rd_go;
  logic                    wr_int_cfg;
  logic                    wr_ctrl2;
  logic                    wr_ctrl3;
  logic                    wr_buf_ctrl;

  assign buffer_mode_bits     = buf_ctrl_q[`SSF_MODE_MSB:`SSF_MODE_LSB];
  assign watermark_level      = buf_ctrl_q[`SSF_WTM_MSB:0];
  assign buf_en               = control_two_q[`SSF_CTRL2_EN_BIT];
  assign stop_on_threshold    = control_two_q[`SSF_CTRL2_STOP_BIT];
  assign overrun_irq_enable   = control_three_q[`SSF_CTRL3_OVR_BIT];
  assign threshold_irq_enable = control_three_q[`SSF_CTRL3_FTH_BIT];
  assign ia                   = interrupt_active_flag_i;

  // Effective behaviour; the flag-triggered modes resolve on the live flag
  always_comb begin
    eff_mode = ssf_pkg::SSF_EFF_BYPASS;
    if (buf_en) begin
      case (buffer_mode_bits)
        `SSF_MODE_BYPASS: eff_mode = ssf_pkg::SSF_EFF_BYPASS;
        `SSF_MODE_FIFO:   eff_mode = ssf_pkg::SSF_EFF_STOP;
        `SSF_MODE_STREAM: eff_mode = ssf_pkg::SSF_EFF_STREAM;
        `SSF_MODE_S2F: begin
          eff_mode = ia ? ssf_pkg::SSF_EFF_STOP : ssf_pkg::SSF_EFF_STREAM;
        end
        `SSF_MODE_B2S: begin
          eff_mode = ia ? ssf_pkg::SSF_EFF_STREAM : ssf_pkg::SSF_EFF_BYPASS;
        end
        `SSF_MODE_DYN:    eff_mode = ssf_pkg::SSF_EFF_DYNAMIC;
        `SSF_MODE_B2F: begin
          eff_mode = ia ? ssf_pkg::SSF_EFF_STOP : ssf_pkg::SSF_EFF_BYPASS;
        end
        default:          eff_mode = ssf_pkg::SSF_EFF_BYPASS;
      endcase
    end
  end

  assign bypass = (eff_mode == ssf_pkg::SSF_EFF_BYPASS);
  assign limit  = stop_on_threshold ? ({1'b0, watermark_level} + `SSF_LVL_ONE)
                                    : `SSF_LVL_W'(`SSF_DEPTH);

  // Start in the same cycle wins; nothing is accessed at the stale address
  assign wr_go       = reg_wr_i && !reg_start_i;
  assign rd_go       = reg_rd_i && !reg_start_i;
  assign wr_int_cfg  = wr_go && (addr_q == `SSF_OFF_INT_CFG);
  assign wr_ctrl2    = wr_go && (addr_q == `SSF_OFF_CTRL2);
  assign wr_ctrl3    = wr_go && (addr_q == `SSF_OFF_CTRL3);
  assign wr_buf_ctrl = wr_go && (addr_q == `SSF_OFF_BUF_CTRL);

  assign acc      = rd_go && (addr_q == `SSF_OFF_TEMP_HI);
  assign fifo_pop = acc && !bypass;

  ssf_buffer #(
    .WIDTH (`SSF_ENTRY_W),
    .DEPTH (`SSF_DEPTH),
    .PW    (`SSF_PTR_W),
    .LW    (`SSF_LVL_W)
  ) u_buffer (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .clear_i     (bypass),
    .overwrite_i (eff_mode == ssf_pkg::SSF_EFF_STREAM ||
                  eff_mode == ssf_pkg::SSF_EFF_DYNAMIC),
    .retain_i    (eff_mode == ssf_pkg::SSF_EFF_STREAM),
    .limit_i     (limit),
    .in_valid_i  (sample_valid_i && !bypass),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({temperature_i, pressure_i}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_head),
    .level_o     (fill_level),
    .overrun_o   (fifo_drop)
  );

  // Stop mode refuses when full; the chain sees it and drops the result
  assign sample_ready_o = bypass || fifo_in_ready;

  // Empty buffer keeps showing the entry read or bypassed last
  assign cur_entry = (!bypass && fifo_out_valid) ? fifo_head : last_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_q <= '0;
    end else if (bypass && sample_valid_i) begin
      last_q <= {temperature_i, pressure_i};
    end else if (fifo_pop && fifo_out_valid) begin
      last_q <= fifo_head;
    end
  end

  assign watermark_flag = (watermark_level != '0) &&
                          (fill_level >= {1'b0, watermark_level});

  // Set wins over the clear that bypass applies
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overrun_flag_q <= 1'b0;
    end else if (fifo_drop) begin
      overrun_flag_q <= 1'b1;
    end else if (bypass) begin
      overrun_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interrupt_pin_o <= 1'b0;
    end else begin
      interrupt_pin_o <= (overrun_irq_enable && overrun_flag_q) ||
                         (threshold_irq_enable && watermark_flag);
    end
  end

  // Access address: loaded at start, advanced after each access
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= '0;
    end else if (reg_start_i) begin
      addr_q <= reg_addr_i;
    end else if (reg_rd_i || reg_wr_i) begin
      if (addr_q == `SSF_OFF_TEMP_HI) begin
        addr_q <= `SSF_OFF_PRESS_LO;
      end else begin
        addr_q <= addr_q + `SSF_ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_cfg_q <= `SSF_RST_REG;
    end else if (wr_int_cfg) begin
      int_cfg_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      control_two_q <= `SSF_RST_REG;
    end else if (wr_ctrl2) begin
      control_two_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      control_three_q <= `SSF_RST_REG;
    end else if (wr_ctrl3) begin
      control_three_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_ctrl_q <= `SSF_RST_REG;
    end else if (wr_buf_ctrl) begin
      buf_ctrl_q <= reg_wdata_i;
    end
  end

  always_comb begin
    status_byte = {watermark_flag, overrun_flag_q, fill_level};
    int_src_byte = '0;
    int_src_byte[`SSF_INTSRC_IA_BIT] = ia;
    case (addr_q)
      `SSF_OFF_INT_CFG:   rdata_d = int_cfg_q;
      `SSF_OFF_CTRL2:     rdata_d = control_two_q;
      `SSF_OFF_CTRL3:     rdata_d = control_three_q;
      `SSF_OFF_BUF_CTRL:  rdata_d = buf_ctrl_q;
      `SSF_OFF_INT_SRC:   rdata_d = int_src_byte;
      `SSF_OFF_STATUS:    rdata_d = status_byte;
      `SSF_OFF_PRESS_LO:  rdata_d = cur_entry[`SSF_DATA_W-1:0];
      `SSF_OFF_PRESS_MID: rdata_d = cur_entry[`SSF_POS_PRESS_MID +: `SSF_DATA_W];
      `SSF_OFF_PRESS_HI:  rdata_d = cur_entry[`SSF_POS_PRESS_HI +: `SSF_DATA_W];
      `SSF_OFF_TEMP_LO:   rdata_d = cur_entry[`SSF_POS_TEMP_LO +: `SSF_DATA_W];
      `SSF_OFF_TEMP_HI:   rdata_d = cur_entry[`SSF_POS_TEMP_HI +: `SSF_DATA_W];
      default:            rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else if (rd_go) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule : ssf_top
